//--- shared/srp_pkg.sv
// Purpose: constants, table and helpers for the serial register port
// Assumes: byte k of a register (k=0 least significant) sits at base plus k
// Notes:   only the port and its byte store use this
package srp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // instruction byte layout
  localparam int unsigned RW_BIT       = 7;     // direction flag position
  localparam int unsigned ADDR_MSB     = 4;     // register address field top
  localparam int unsigned ADDR_LSB     = 0;     // register address field bottom
  localparam logic [2:0]  LAST_BIT_IDX = 3'h7;  // eighth bit of a byte
  localparam logic [4:0]  ADDR_ONE     = 5'h01; // byte address step

  // byte store geometry
  localparam int unsigned MEM_AW      = 5;      // byte address width
  localparam int unsigned MEM_DEPTH   = 32;     // bytes held
  localparam logic [7:0]  MEM_RST_VAL = 8'h00;  // contents after reset

  // port configuration bits inside register zero
  localparam logic [4:0] CFG_PIN_BYTE_ADDR   = 5'h00; // byte holding bit 7
  localparam logic [2:0] CFG_PIN_BIT         = 3'h7;  // pin mode, 1 = separate out
  localparam logic [4:0] CFG_ORDER_BYTE_ADDR = 5'h01; // byte holding bit 8
  localparam logic [2:0] CFG_ORDER_BIT       = 3'h0;  // order, 1 = lsb first
  localparam logic       CFG_SEP_OUT_RST     = 1'b0;  // bidirectional after reset
  localparam logic       CFG_LSB_FIRST_RST   = 1'b0;  // msb first after reset

  // link timing for the host; the bench host model runs a 6 ns period, below SCLK_MIN_PERIOD_NS
  localparam int unsigned SCLK_MAX_MHZ       = 25;
  localparam int unsigned SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;

  // register table: byte width and lowest byte address per register
  localparam logic [4:0] NUM_MAPPED_REGS = 5'h06;
  localparam logic [2:0] REG_WIDTH_TBL [6] = '{3'h4, 3'h3, 3'h2, 3'h1, 3'h4, 3'h2};
  localparam logic [4:0] REG_BASE_TBL  [6] = '{5'h00, 5'h04, 5'h07, 5'h09, 5'h0A, 5'h0E};
  localparam logic [2:0] UNMAPPED_WIDTH = 3'h1;  // unused addresses: one byte
  localparam logic [4:0] UNMAPPED_BASE  = 5'h1F; // scratch byte

  typedef enum logic [1:0] {
    ST_INSTR = 2'b01,
    ST_DATA  = 2'b10
  } srp_state_e;

  // byte width of a register
  function automatic logic [2:0] reg_width(input logic [4:0] a);
    reg_width = (a < NUM_MAPPED_REGS) ? REG_WIDTH_TBL[a[2:0]] : UNMAPPED_WIDTH;
  endfunction

  // first byte address of a transfer, by order
  function automatic logic [4:0] first_addr(input logic [4:0] a, input logic lsb);
    logic [4:0] b;
    b = (a < NUM_MAPPED_REGS) ? REG_BASE_TBL[a[2:0]] : UNMAPPED_BASE;
    first_addr = lsb ? b : 5'(b + {2'b00, reg_width(a)} - ADDR_ONE);
  endfunction

  // next byte address: up in lsb order, down in msb order
  function automatic logic [4:0] step_addr(input logic [4:0] a, input logic lsb);
    step_addr = lsb ? 5'(a + ADDR_ONE) : 5'(a - ADDR_ONE);
  endfunction

  // bit position within a byte of the n-th bit on the wire
  function automatic logic [2:0] bit_pos(input logic [2:0] n, input logic lsb);
    bit_pos = lsb ? n : 3'(LAST_BIT_IDX - n);
  endfunction

endpackage

//--- hdl/srp_sync2.sv
// Purpose: two-flop level synchroniser
// Assumes: input is a slow level, never a pulse
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
module srp_sync2 #(
  parameter logic RST_VAL = 1'b0  // value shown during reset
) (
  input  wire logic i_clk,        // destination clock
  input  wire logic i_rst_n,      // synchronous, active low
  input  wire logic i_d,          // level from another domain
  output logic      o_q           // synchronised level
);

  logic meta_r;  // may go metastable, read only by q_r
  logic q_r;     // settled copy

  //////////////////////////////////////////////////////////////////////////////
  // two stages on the destination clock
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= RST_VAL;
      q_r    <= RST_VAL;
    end else begin
      meta_r <= i_d;
      q_r    <= meta_r;
    end
  end

  assign o_q = q_r;

endmodule

//--- hdl/srp_byte_mem.sv
// Purpose: byte store behind the serial port
// Assumes: one write and one read per clock edge
// Notes:   read data registered; reset clears every byte
`timescale 1ns/1ps
module srp_byte_mem (
  input  wire logic                      i_clk,    // serial clock
  input  wire logic                      i_rst_n,  // synchronous, active low
  input  wire logic                      i_we,     // write this edge
  input  wire logic [srp_pkg::MEM_AW-1:0] i_waddr, // write byte address
  input  wire logic [7:0]                i_wdata,  // write byte
  input  wire logic [srp_pkg::MEM_AW-1:0] i_raddr, // read byte address
  output logic      [7:0]                o_rdata   // registered read byte
);

  logic [7:0] mem_r [srp_pkg::MEM_DEPTH];  // stored bytes
  logic [7:0] rdata_r;                     // read register

  //////////////////////////////////////////////////////////////////////////////
  // write port; reset only from system reset, never from resync
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < srp_pkg::MEM_DEPTH; i++) begin
        mem_r[i] <= srp_pkg::MEM_RST_VAL;
      end
    end else if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // read port, old data on a same-address write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_r <= srp_pkg::MEM_RST_VAL;
    end else begin
      rdata_r <= mem_r[i_raddr];
    end
  end

  assign o_rdata = rdata_r;

endmodule

//--- hdl/srp_serial_register_port.sv
// Purpose: serial register port: instruction byte, then whole-register data
// Assumes: serial clock runs while a reset or resync is to take effect
// Notes:   link logic on the serial clock; status levels cross to system clock
//          a read bit is relaunched while deselected, so a resumed read is right
`timescale 1ns/1ps
module srp_serial_register_port (
  input  wire logic i_sys_clk,             // system clock, 10 MHz
  input  wire logic i_rstn,                // synchronous, active low
  input  wire logic i_serial_clk,          // serial clock from the host
  input  wire logic i_chip_select_n,       // active low select
  input  wire logic i_data_io_in,          // io pin level
  output logic      o_data_io_out,         // io pin drive value
  output logic      o_data_io_oe,          // io pin drive enable
  output logic      o_serial_data_out,     // separate output value
  output logic      o_serial_data_out_oe,  // separate output enable
  input  wire logic i_port_resync,         // high aborts the cycle
  output logic      o_cfg_lsb_first,       // order setting, system clock
  output logic      o_cfg_separate_out,    // pin mode, system clock
  output logic      o_cycle_busy           // cycle under way, system clock
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                   sclk_rst_n;    // system reset seen on serial clock
  logic                   resync_s;      // synchronised resync level
  logic                   cs_act;        // select asserted
  srp_pkg::srp_state_e    state_r;       // instruction or data phase
  logic [2:0]             bit_cnt_r;     // bits taken in current byte
  logic [7:0]             rx_byte_r;     // byte being assembled
  logic [7:0]             rx_byte_nxt;   // byte with this edge's bit
  logic                   rw_r;          // latched direction flag
  logic [2:0]             bytes_left_r;  // bytes still to move
  logic [4:0]             byte_addr_r;   // current internal byte address
  logic [4:0]             byte_addr_nxt; // address for the next edge
  logic                   sep_out_r;     // pin mode, 1 = separate output
  logic                   lsb_first_r;   // bit order, 1 = lsb first
  logic                   lsb_nxt;       // order after this edge's write
  logic                   byte_done;     // eighth bit arrives this edge
  logic                   step_w;        // live edge: selected, no resync
  logic                   mem_we;        // commit a written byte
  logic [7:0]             rd_data_w;     // byte being read out
  logic                   read_phase_w;  // in a read data phase
  logic                   tx_bit_r;      // launched read bit
  logic                   busy_r;        // status level for system side
  logic [4:0]             instr_addr_w;  // address field of the instruction

  //////////////////////////////////////////////////////////////////////////////
  // crossings into the serial domain
  // reset is a level, so two flops do; its own flops cannot be reset
  srp_sync2 #(.RST_VAL(1'b0)) u_rst_sync (
    .i_clk   (i_serial_clk),
    .i_rst_n (1'b1),
    .i_d     (i_rstn),
    .o_q     (sclk_rst_n)
  );

  // resync is a pin level; it needs clock edges to be seen
  srp_sync2 #(.RST_VAL(1'b0)) u_resync_sync (
    .i_clk   (i_serial_clk),
    .i_rst_n (sclk_rst_n),
    .i_d     (i_port_resync),
    .o_q     (resync_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // edge qualifiers
  assign cs_act       = !i_chip_select_n;
  assign step_w       = cs_act && !resync_s;           // select high holds all
  assign byte_done    = (bit_cnt_r == srp_pkg::LAST_BIT_IDX);
  assign read_phase_w = (state_r == srp_pkg::ST_DATA) && rw_r;
  assign instr_addr_w = rx_byte_nxt[srp_pkg::ADDR_MSB:srp_pkg::ADDR_LSB];

  // place the incoming bit by the order in force, instruction included
  always_comb begin
    rx_byte_nxt = rx_byte_r;
    rx_byte_nxt[srp_pkg::bit_pos(bit_cnt_r, lsb_first_r)] = i_data_io_in;
  end

  // a write to the order byte changes the stepping of this very cycle
  always_comb begin
    lsb_nxt = lsb_first_r;
    if (mem_we && byte_addr_r == srp_pkg::CFG_ORDER_BYTE_ADDR) begin
      lsb_nxt = rx_byte_nxt[srp_pkg::CFG_ORDER_BIT];
    end
  end

  // next byte address, also the read address of the store
  always_comb begin
    byte_addr_nxt = byte_addr_r;
    if (step_w && byte_done) begin
      if (state_r == srp_pkg::ST_INSTR) begin
        byte_addr_nxt = srp_pkg::first_addr(instr_addr_w, lsb_first_r);
      end else if (bytes_left_r != 3'h1) begin
        byte_addr_nxt = srp_pkg::step_addr(byte_addr_r, lsb_nxt);
      end else begin
        byte_addr_nxt = byte_addr_r; // last byte, address unused
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // phase state; resync aborts but leaves the store alone
  always_ff @(posedge i_serial_clk) begin
    if (!sclk_rst_n) begin
      state_r <= srp_pkg::ST_INSTR;
    end else if (resync_s) begin
      state_r <= srp_pkg::ST_INSTR;
    end else if (cs_act && byte_done) begin
      case (state_r)
        srp_pkg::ST_INSTR: begin
          state_r <= srp_pkg::ST_DATA;
        end
        srp_pkg::ST_DATA: begin
          if (bytes_left_r == 3'h1) begin
            state_r <= srp_pkg::ST_INSTR;
          end
        end
        default: begin
          state_r <= srp_pkg::ST_INSTR;
        end
      endcase
    end
  end

  // bit counter and assembly; select high freezes both
  always_ff @(posedge i_serial_clk) begin
    if (!sclk_rst_n || resync_s) begin
      bit_cnt_r <= 3'h0;
      rx_byte_r <= 8'h00;
    end else if (cs_act) begin
      bit_cnt_r <= 3'(bit_cnt_r + 3'h1);
      rx_byte_r <= byte_done ? 8'h00 : rx_byte_nxt;
    end
  end

  // instruction decode: direction, byte count, address walk
  always_ff @(posedge i_serial_clk) begin
    if (!sclk_rst_n) begin
      rw_r         <= 1'b0;
      bytes_left_r <= 3'h0;
      byte_addr_r  <= 5'h00;
    end else if (step_w && byte_done) begin
      if (state_r == srp_pkg::ST_INSTR) begin
        rw_r         <= rx_byte_nxt[srp_pkg::RW_BIT];
        bytes_left_r <= srp_pkg::reg_width(instr_addr_w);
      end else begin
        bytes_left_r <= 3'(bytes_left_r - 3'h1);
      end
      byte_addr_r <= byte_addr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // byte store; writes always arrive on the io pin
  assign mem_we = step_w && byte_done && (state_r == srp_pkg::ST_DATA) && !rw_r;

  srp_byte_mem u_mem (
    .i_clk   (i_serial_clk),
    .i_rst_n (sclk_rst_n),
    .i_we    (mem_we),
    .i_waddr (byte_addr_r),
    .i_wdata (rx_byte_nxt),
    .i_raddr (byte_addr_nxt),
    .o_rdata (rd_data_w)
  );

  // port configuration mirrors; reset only by system reset
  always_ff @(posedge i_serial_clk) begin
    if (!sclk_rst_n) begin
      sep_out_r   <= srp_pkg::CFG_SEP_OUT_RST;
      lsb_first_r <= srp_pkg::CFG_LSB_FIRST_RST;
    end else if (mem_we) begin
      if (byte_addr_r == srp_pkg::CFG_PIN_BYTE_ADDR) begin
        sep_out_r <= rx_byte_nxt[srp_pkg::CFG_PIN_BIT];
      end
      lsb_first_r <= lsb_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read launch on the falling edge; host samples on the next rising one
  // not gated by select: a host may deselect between rise and fall
  always_ff @(negedge i_serial_clk) begin
    if (!sclk_rst_n) begin
      tx_bit_r <= 1'b0;
    end else if (read_phase_w) begin
      tx_bit_r <= rd_data_w[srp_pkg::bit_pos(bit_cnt_r, lsb_first_r)];
    end
  end

  // enables follow the select pin at once, not a clock edge
  assign o_data_io_out        = tx_bit_r;
  assign o_serial_data_out    = tx_bit_r;
  assign o_data_io_oe         = cs_act && read_phase_w && !sep_out_r;
  assign o_serial_data_out_oe = cs_act && read_phase_w && sep_out_r;

  //////////////////////////////////////////////////////////////////////////////
  // status toward the system clock, levels only; bytes are too fast to cross
  always_ff @(posedge i_serial_clk) begin
    if (!sclk_rst_n) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_r == srp_pkg::ST_DATA) || (bit_cnt_r != 3'h0);
    end
  end

  srp_sync2 #(.RST_VAL(srp_pkg::CFG_LSB_FIRST_RST)) u_lsb_sync (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rstn),
    .i_d     (lsb_first_r),
    .o_q     (o_cfg_lsb_first)
  );

  srp_sync2 #(.RST_VAL(srp_pkg::CFG_SEP_OUT_RST)) u_sep_sync (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rstn),
    .i_d     (sep_out_r),
    .o_q     (o_cfg_separate_out)
  );

  srp_sync2 #(.RST_VAL(1'b0)) u_busy_sync (
    .i_clk   (i_sys_clk),
    .i_rst_n (i_rstn),
    .i_d     (busy_r),
    .o_q     (o_cycle_busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks on the serial domain
  instr_phase_end_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (state_r == srp_pkg::ST_INSTR && step_w && byte_done) |=> (state_r == srp_pkg::ST_DATA)
  ) else $error("instruction byte did not open the data phase");

  direction_flag_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (state_r == srp_pkg::ST_INSTR && step_w && byte_done)
      |=> (rw_r == $past(rx_byte_nxt[srp_pkg::RW_BIT]))
  ) else $error("direction flag not taken from bit seven");

  byte_count_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (state_r == srp_pkg::ST_INSTR && step_w && byte_done)
      |=> (bytes_left_r == srp_pkg::reg_width($past(rx_byte_nxt[4:0])))
  ) else $error("byte count does not match register width");

  cycle_end_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (state_r == srp_pkg::ST_DATA && step_w && byte_done && bytes_left_r == 3'h1)
      |=> (state_r == srp_pkg::ST_INSTR && bit_cnt_r == 3'h0)
  ) else $error("cycle did not end after last byte");

  addr_walk_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (state_r == srp_pkg::ST_DATA && step_w && byte_done && bytes_left_r > 3'h1)
      |=> (byte_addr_r == srp_pkg::step_addr($past(byte_addr_r), lsb_first_r))
  ) else $error("byte address stepped the wrong way");

  suspend_hold_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (i_chip_select_n && !resync_s) |=> ($stable(state_r) && $stable(bit_cnt_r))
  ) else $error("progress changed while select was high");

  resync_abort_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    resync_s |=> (state_r == srp_pkg::ST_INSTR && bit_cnt_r == 3'h0)
  ) else $error("resync did not restart the cycle");

  order_update_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (mem_we && byte_addr_r == srp_pkg::CFG_ORDER_BYTE_ADDR)
      |=> (lsb_first_r == $past(rx_byte_nxt[0]))
  ) else $error("order bit not applied at once");

  pins_released_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (i_chip_select_n || !sep_out_r) |-> !o_serial_data_out_oe
  ) else $error("separate output driven when it must be released");

  io_released_a: assert property (
    @(negedge i_serial_clk) disable iff (!sclk_rst_n)
    i_chip_select_n |-> !o_data_io_oe
  ) else $error("io pin driven with select high");

  // reset, register table and read pins
  reset_state_a: assert property (
    @(posedge i_serial_clk)
    !sclk_rst_n |=> (state_r == srp_pkg::ST_INSTR && bit_cnt_r == 3'h0
      && lsb_first_r == srp_pkg::CFG_LSB_FIRST_RST
      && sep_out_r == srp_pkg::CFG_SEP_OUT_RST)
  ) else $error("port not idle with default settings after reset");

  width_range_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (state_r == srp_pkg::ST_DATA)
      |-> (bytes_left_r != 3'h0 && bytes_left_r <= 3'h4)
  ) else $error("data phase byte count out of range");

  first_addr_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (state_r == srp_pkg::ST_INSTR && step_w && byte_done)
      |=> (byte_addr_r == srp_pkg::first_addr($past(instr_addr_w), lsb_first_r))
  ) else $error("first byte address does not match register table");

  launch_bit_a: assert property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (cs_act && read_phase_w)
      |-> (o_data_io_out == rd_data_w[srp_pkg::bit_pos(bit_cnt_r, lsb_first_r)])
  ) else $error("read bit on the pin is not the one due");

  pin_role_a: assert property (
    @(negedge i_serial_clk) disable iff (!sclk_rst_n)
    (!i_chip_select_n && state_r == srp_pkg::ST_DATA && rw_r)
      |-> (o_data_io_oe != sep_out_r && o_serial_data_out_oe == sep_out_r)
  ) else $error("read data phase drives the wrong pin");

  // main scenarios
  write_cycle_c: cover property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (mem_we && bytes_left_r == 3'h1)
  );

  read_cycle_c: cover property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (read_phase_w && step_w && byte_done && bytes_left_r == 3'h1)
  );

  suspend_c: cover property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (state_r == srp_pkg::ST_DATA && i_chip_select_n)
  );

  resync_c: cover property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (resync_s && state_r == srp_pkg::ST_DATA)
  );

  lsb_cycle_c: cover property (
    @(posedge i_serial_clk) disable iff (!sclk_rst_n)
    (lsb_first_r && mem_we && bytes_left_r == 3'h1)
  );

endmodule

//--- testbench/srp_host_model.sv
// Purpose: host model that drives the serial link of the register port
// Assumes: 6 ns serial period; the host owns the serial clock and the select
// Notes:   clock stands still between calls; a released data line shows no stale level
`timescale 1ns/1ps
module srp_host_model (
  output logic      o_sclk,   // serial clock
  output logic      o_cs_n,   // select, active low
  output logic      o_d,      // io pin value shown by the host
  output logic      o_d_oe,   // host drives the io pin
  output logic      o_resync, // abort request
  input  wire logic i_io,     // resolved io pin level
  input  wire logic i_io_oe,  // device drives io pin
  input  wire logic i_sdo,    // separate output level
  input  wire logic i_sdo_oe  // device drives separate output
);
  int unsigned oe_bad; // edges where the wrong pin was driven
  int          nbit;   // bits moved in this frame

  ////////////////////////////////////////////////////////////////////////////////
  // idle at time zero: deselected, clock low
  initial begin
    o_sclk   = 1'b0;
    o_cs_n   = 1'b1;
    o_d      = 1'b0;
    o_d_oe   = 1'b1;
    o_resync = 1'b0;
    oe_bad   = 0;
  end

  // deselected edges: suspend, reset and resync need a running clock
  task automatic idle(input int n);
    repeat (n) begin
      #1 o_cs_n = 1'b1; // one step after the falling edge, never on it
      o_d_oe = 1'b0;
      o_d    = ~o_d; // toggle so a stale level is never mistaken for data
      #2 o_sclk = 1'b1;
      if (i_io_oe | i_sdo_oe) oe_bad++;
      #3 o_sclk = 1'b0;
    end
  endtask

  // one bit: change after the falling edge, sample just before the rise
  task automatic bit_x(input logic b, input logic rd, input logic sep, input int susp,
                       output logic r);
    if (nbit == susp) idle(3);
    #1 o_cs_n = 1'b0;
    o_d_oe = !rd;
    o_d    = rd ? ~o_d : b;
    #2 r = sep ? i_sdo : i_io;
    if (i_io_oe && o_d_oe) oe_bad++;
    if (rd && (i_io_oe !== !sep || i_sdo_oe !== sep)) oe_bad++;
    o_sclk = 1'b1;
    #3 o_sclk = 1'b0;
    nbit++;
  endtask

  // instruction then nb bytes of a register of w bytes, in the given order
  task automatic frame(input logic [7:0] ins, input int w, input int nb, input logic lsb,
                       input logic sep, input int susp, input logic [31:0] wv,
                       output logic [31:0] rv);
    int   idx;
    int   p;
    logic r;
    nbit = 0;
    rv   = '0;
    for (int i = 0; i < 8; i++) bit_x(ins[lsb ? i : 7-i], 1'b0, sep, susp, r);
    for (int k = 0; k < nb; k++) begin
      idx = lsb ? k : w-1-k;
      for (int i = 0; i < 8; i++) begin
        p = idx*8 + (lsb ? i : 7-i);
        bit_x(wv[p], ins[7], sep, susp, r);
        rv[p] = r;
      end
    end
  endtask

  // abort: high across deselected edges, then low before the next frame
  task automatic resync();
    o_resync = 1'b1;
    idle(4);
    o_resync = 1'b0;
    idle(4);
  endtask
endmodule

//--- testbench/srp_serial_register_port_tb.sv
// Purpose: self-checking bench for the serial register port
// Assumes: register widths 4,3,2,1,4,2 for addresses 0..5, others one byte
// Notes:   random data and suspend points from a fixed seed
`timescale 1ns/1ps
module srp_serial_register_port_tb;
  logic        i_sys_clk, i_rstn;            // system side
  logic        sclk, cs_n, hd, hd_oe, rsy;   // host drive
  logic        io_out, io_oe, serial_data_out, sdo_oe;   // device drive
  logic        cfg_lsb, cfg_sep, busy;       // status levels
  logic        io_wire;                      // resolved io pin
  logic [31:0] regv [8];                     // expected register values
  logic [31:0] rv;                           // read result
  integer      seed;
  int          failures, n_compared;

  assign io_wire = io_oe ? io_out : hd; // host toggles its level once released

  srp_serial_register_port DUT (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_serial_clk(sclk),
    .i_chip_select_n(cs_n), .i_data_io_in(io_wire), .o_data_io_out(io_out),
    .o_data_io_oe(io_oe), .o_serial_data_out(serial_data_out), .o_serial_data_out_oe(sdo_oe),
    .i_port_resync(rsy), .o_cfg_lsb_first(cfg_lsb), .o_cfg_separate_out(cfg_sep),
    .o_cycle_busy(busy));

  srp_host_model HOST (.o_sclk(sclk), .o_cs_n(cs_n), .o_d(hd), .o_d_oe(hd_oe),
    .o_resync(rsy), .i_io(io_wire), .i_io_oe(io_oe), .i_sdo(serial_data_out), .i_sdo_oe(sdo_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // system clock, 100 ns
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // byte width per register address
  function automatic int wid(input logic [4:0] a);
    case (a)
      5'h00, 5'h04: wid = 4;
      5'h01:        wid = 3;
      5'h02, 5'h05: wid = 2;
      default:      wid = 1;
    endcase
  endfunction

  // bits that a register of w bytes really holds
  function automatic logic [31:0] msk(input int w);
    msk = (w == 4) ? 32'hFFFFFFFF : (32'h1 << (8*w)) - 32'h1;
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t level got %b exp %b", $time, got, exp);
    end
  endtask

  // write a whole register then read it back; ignored instruction bits random
  task automatic wr_rd(input logic [4:0] a, input logic [31:0] v, input logic lsb,
                       input logic sep);
    logic [1:0] junk;
    junk = 2'($random(seed));
    HOST.frame({1'b0, junk, a}, wid(a), wid(a), lsb, sep,
               int'($unsigned($random(seed)) % 48), v, rv);
    regv[a] = v & msk(wid(a));
    HOST.frame({1'b1, ~junk, a}, wid(a), wid(a), lsb, sep, 99, 32'h0, rv);
    chk_word(rv, regv[a]);
  endtask

  task automatic wrap_up();
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // hang guard
  initial begin
    #1000000;
    failures++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed       = 32'hABF37890;
    failures   = 0;
    n_compared = 0;
    i_rstn     = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    HOST.idle(8);
    @(negedge i_sys_clk) i_rstn = 1'b1;
    HOST.idle(4);
    repeat (3) @(negedge i_sys_clk);
    chk_bit(cfg_lsb, 1'b0);
    chk_bit(cfg_sep, 1'b0);
    chk_bit(io_oe | sdo_oe, 1'b0);
    // addresses 0 to 7 once, then random ones among them; config bits kept clear
    for (int i = 0; i < 14; i++)
      wr_rd(i < 8 ? 5'(i) : 5'($unsigned($random(seed)) % 8),
            $random(seed) & ~32'h180, 1'b0, 1'b0);
    // abort after two of four bytes: committed bytes stay
    HOST.frame(8'h04, 4, 2, 1'b0, 1'b0, 99, 32'hA1B2C3D4, rv);
    repeat (3) @(negedge i_sys_clk);
    chk_bit(busy, 1'b1);
    HOST.resync();
    regv[4] = {16'hA1B2, regv[4][15:0]};
    HOST.frame(8'h84, 4, 4, 1'b0, 1'b0, 99, 32'h0, rv);
    chk_word(rv, regv[4]);
    // order bit set by a partial register-zero write, then abort
    HOST.frame(8'h00, 4, 3, 1'b0, 1'b0, 99, 32'h5A6B0100, rv);
    HOST.resync();
    repeat (4) @(negedge i_sys_clk);
    chk_bit(cfg_lsb, 1'b1);
    // lsb order with the separate output
    wr_rd(5'h00, $random(seed) | 32'h180, 1'b1, 1'b1);
    wr_rd(5'h04, $random(seed), 1'b1, 1'b1);
    wr_rd(5'h01, $random(seed), 1'b1, 1'b1);
    HOST.idle(2);
    repeat (4) @(negedge i_sys_clk);
    chk_bit(cfg_sep, 1'b1);
    chk_bit(busy, 1'b0);
    chk_word(HOST.oe_bad, 32'h0);
    wrap_up();
  end
endmodule
